/* mda_buf.sv */
// Two-entry valid/ready buffer in the input data path
`timescale 1ns/1ps
module mda_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
)
(
  input logic clk_in,
  input logic rst_b_in,
  input logic in_valid_in,
  input logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input logic out_ready_in,
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } mda_buf_s;
  mda_buf_s st;
  mda_buf_s next_st;
  logic push;
  logic pop;
  assign in_ready_out = st.cnt != CW'(DEPTH);
  assign out_valid_out = st.cnt != '0;
  assign out_data_out = st.mem[st.rp];
  assign count_out = st.cnt;
  always_comb
  begin
    next_st = st;
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    if (push)
    begin
      next_st.mem[st.wp] = in_data_in;
      next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
    end
    if (pop)
      next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
    next_st.cnt = st.cnt + CW'(push) - CW'(pop);
  end
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      st <= '0;
    else
      st <= next_st;
  end
endmodule // mda_buf

/* mda_dma_model.sv */
// Behavioural DMA channel feeding the engine's write port
`timescale 1ns/1ps
module mda_dma_model
(
  input logic clk_in,
  input logic go_in,
  input logic [5:0] words_in,
  input logic burst_in,
  input logic req_in,
  input logic ready_in,
  output logic valid_out,
  output logic [31:0] data_out,
  output logic idle_out
);
  logic [5:0] left = 6'h0;
  logic [5:0] beat = 6'h0;
  logic [31:0] cur = 32'h0;
  initial valid_out = 1'b0;
  assign idle_out = (left == 6'h0);
  // Released data line shows the inverse of the next word
  assign data_out = valid_out ? cur : ~cur;
  always @(posedge clk_in)
    if (go_in)
    begin
      left <= words_in;
      cur <= 32'h00010000;
    end
    else if (valid_out && ready_in)
    begin
      left <= left - 6'h1;
      beat <= beat - 6'h1;
      cur <= cur + 32'h1;
      valid_out <= (beat != 6'h1) && (left != 6'h1);
    end
    else if (!valid_out && req_in && left != 6'h0)
    begin
      beat <= burst_in ? mda_pkg::DMA_BURST : mda_pkg::DMA_SINGLE;
      valid_out <= 1'b1;
    end
endmodule // mda_dma_model

/* mda_pkg.sv */
// Constants, tables and helper functions of the message digest engine
package mda_pkg;
  typedef enum logic [1:0] {MDA_SHA1, MDA_SHA224, MDA_SHA256, MDA_MD5}
    mda_algo_e;
  typedef enum logic [1:0] {MDA_SW_NONE, MDA_SW_HALF, MDA_SW_BYTE,
    MDA_SW_BIT} mda_swap_e;
  typedef enum logic [2:0] {MDA_IDLE, MDA_FILL, MDA_PROC, MDA_PAD,
    MDA_DONE} mda_state_e;
  localparam logic [4:0] FIFO_WORDS = 5'h10;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [6:0] BLK_CYC_SHA1 = 7'h52;
  localparam logic [6:0] BLK_CYC_SHA2 = 7'h42;
  localparam logic [6:0] BLK_CYC_MD5 = 7'h42;
  localparam logic [6:0] ROUNDS_SHA1 = BLK_CYC_SHA1 - 7'h2;
  localparam logic [6:0] ROUNDS_SHA2 = BLK_CYC_SHA2 - 7'h2;
  localparam logic [6:0] ROUNDS_MD5 = BLK_CYC_MD5 - 7'h2;
  localparam logic [63:0] LEN_STEP = 64'h20;
  localparam logic [31:0] PAD_ONE = 32'h80000000;
  localparam logic [5:0] DMA_BURST = 6'h04;
  localparam logic [5:0] DMA_SINGLE = 6'h01;
  localparam logic [4:0] RD_DIG = 5'h10;
  localparam logic [4:0] RD_LEN_LO = 5'h18;
  localparam logic [4:0] RD_LEN_HI = 5'h19;
  localparam logic [4:0] RD_CNT = 5'h1A;
  localparam logic [31:0] IV_SHA1 [8] = '{32'h67452301, 32'hEFCDAB89,
    32'h98BADCFE, 32'h10325476, 32'hC3D2E1F0, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] IV_SHA224 [8] = '{32'hC1059ED8, 32'h367CD507,
    32'h3070DD17, 32'hF70E5939, 32'hFFC00B31, 32'h68581511, 32'h64F98FA7,
    32'hBEFA4FA4};
  localparam logic [31:0] IV_SHA256 [8] = '{32'h6A09E667, 32'hBB67AE85,
    32'h3C6EF372, 32'hA54FF53A, 32'h510E527F, 32'h9B05688C, 32'h1F83D9AB,
    32'h5BE0CD19};
  localparam logic [31:0] IV_MD5 [8] = '{32'h67452301, 32'hEFCDAB89,
    32'h98BADCFE, 32'h10325476, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] K_SHA1 [4] = '{32'h5A827999, 32'h6ED9EBA1,
    32'h8F1BBCDC, 32'hCA62C1D6};
  localparam logic [4:0] S_MD5 [16] = '{5'h07, 5'h0C, 5'h11, 5'h16,
    5'h05, 5'h09, 5'h0E, 5'h14, 5'h04, 5'h0B, 5'h10, 5'h17,
    5'h06, 5'h0A, 5'h0F, 5'h15};
  localparam logic [31:0] K_SHA2 [64] = '{
    32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5, 32'h3956C25B,
    32'h59F111F1, 32'h923F82A4, 32'hAB1C5ED5, 32'hD807AA98, 32'h12835B01,
    32'h243185BE, 32'h550C7DC3, 32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7,
    32'hC19BF174, 32'hE49B69C1, 32'hEFBE4786, 32'h0FC19DC6, 32'h240CA1CC,
    32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA, 32'h983E5152,
    32'hA831C66D, 32'hB00327C8, 32'hBF597FC7, 32'hC6E00BF3, 32'hD5A79147,
    32'h06CA6351, 32'h14292967, 32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC,
    32'h53380D13, 32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85,
    32'hA2BFE8A1, 32'hA81A664B, 32'hC24B8B70, 32'hC76C51A3, 32'hD192E819,
    32'hD6990624, 32'hF40E3585, 32'h106AA070, 32'h19A4C116, 32'h1E376C08,
    32'h2748774C, 32'h34B0BCB5, 32'h391C0CB3, 32'h4ED8AA4A, 32'h5B9CCA4F,
    32'h682E6FF3, 32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208,
    32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2};
  localparam logic [31:0] K_MD5 [64] = '{
    32'hD76AA478, 32'hE8C7B756, 32'h242070DB, 32'hC1BDCEEE, 32'hF57C0FAF,
    32'h4787C62A, 32'hA8304613, 32'hFD469501, 32'h698098D8, 32'h8B44F7AF,
    32'hFFFF5BB1, 32'h895CD7BE, 32'h6B901122, 32'hFD987193, 32'hA679438E,
    32'h49B40821, 32'hF61E2562, 32'hC040B340, 32'h265E5A51, 32'hE9B6C7AA,
    32'hD62F105D, 32'h02441453, 32'hD8A1E681, 32'hE7D3FBC8, 32'h21E1CDE6,
    32'hC33707D6, 32'hF4D50D87, 32'h455A14ED, 32'hA9E3E905, 32'hFCEFA3F8,
    32'h676F02D9, 32'h8D2A4C8A, 32'hFFFA3942, 32'h8771F681, 32'h6D9D6122,
    32'hFDE5380C, 32'hA4BEEA44, 32'h4BDECFA9, 32'hF6BB4B60, 32'hBEBFBC70,
    32'h289B7EC6, 32'hEAA127FA, 32'hD4EF3085, 32'h04881D05, 32'hD9D4D039,
    32'hE6DB99E5, 32'h1FA27CF8, 32'hC4AC5665, 32'hF4292244, 32'h432AFF97,
    32'hAB9423A7, 32'hFC93A039, 32'h655B59C3, 32'h8F0CCC92, 32'hFFEFF47D,
    32'h85845DD1, 32'h6FA87E4F, 32'hFE2CE6E0, 32'hA3014314, 32'h4E0811A1,
    32'hF7537E82, 32'hBD3AF235, 32'h2AD7D2BB, 32'hEB86D391};
  function automatic logic [31:0] bswap(logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  function automatic logic [31:0] rotl(logic [31:0] x, logic [4:0] n);
    logic [63:0] d;
    d = {x, x} << n;
    return d[63:32];
  endfunction
  function automatic logic [31:0] rotr(logic [31:0] x, logic [4:0] n);
    logic [63:0] d;
    d = {x, x} >> n;
    return d[31:0];
  endfunction
  function automatic logic [31:0] swap_word(logic [31:0] x,
    logic [1:0] mode);
    logic [31:0] r;
    r = x;
    unique case (mda_swap_e'(mode))
      MDA_SW_NONE: r = x;
      MDA_SW_HALF: r = {x[15:0], x[31:16]};
      MDA_SW_BYTE: r = bswap(x);
      MDA_SW_BIT:
        for (int i = 0; i < 32; i++)
          r[i] = x[31 - i];
    endcase
    return r;
  endfunction
endpackage

/* mda_round.sv */
// One compression round for SHA-1, SHA-2 and MD5; schedule step for SHA-1 and SHA-2 only
`timescale 1ns/1ps
module mda_round
(
  input logic [1:0] algo_in,
  input logic [6:0] t_in,
  input logic [7:0][31:0] st_in,
  input logic [15:0][31:0] win_in,
  output logic [7:0][31:0] st_out,
  output logic [31:0] w_next_out
);
  logic [31:0] a, b, c, d, e, f, g, h, fn, t1, t2, s0, s1;
  logic [3:0] gi;
  logic [1:0] grp;
  always_comb
  begin
    {h, g, f, e, d, c, b, a} = st_in;
    st_out = st_in;
    fn = '0;
    t1 = '0;
    t2 = '0;
    s0 = '0;
    s1 = '0;
    gi = '0;
    grp = '0;
    w_next_out = win_in[0];
    unique case (mda_pkg::mda_algo_e'(algo_in))
      mda_pkg::MDA_SHA1:
      begin
        grp = (t_in < 7'h14) ? 2'h0 : (t_in < 7'h28) ? 2'h1 :
          (t_in < 7'h3C) ? 2'h2 : 2'h3;
        fn = (grp == 2'h0) ? ((b & c) | (~b & d)) :
          (grp == 2'h2) ? ((b & c) | (b & d) | (c & d)) : (b ^ c ^ d);
        t1 = mda_pkg::rotl(a, 5'h05) + fn + e + mda_pkg::K_SHA1[grp] +
          win_in[0];
        st_out[4:0] = {d, c, mda_pkg::rotl(b, 5'h1E), a, t1};
        w_next_out = mda_pkg::rotl(win_in[13] ^ win_in[8] ^ win_in[2] ^
          win_in[0], 5'h01);
      end
      mda_pkg::MDA_MD5:
      begin
        grp = t_in[5:4];
        unique case (grp)
          2'h0: begin fn = (b & c) | (~b & d); gi = t_in[3:0]; end
          2'h1: begin fn = (d & b) | (~d & c); gi = t_in[3:0] * 4'h5 + 4'h1;
          end
          2'h2: begin fn = b ^ c ^ d; gi = t_in[3:0] * 4'h3 + 4'h5; end
          2'h3: begin fn = c ^ (b | ~d); gi = t_in[3:0] * 4'h7; end
        endcase
        // Stream words are byte reversed into little-endian form
        t1 = a + fn + mda_pkg::K_MD5[t_in[5:0]] +
          mda_pkg::bswap(win_in[gi]);
        t2 = b + mda_pkg::rotl(t1, mda_pkg::S_MD5[{grp, t_in[1:0]}]);
        st_out[3:0] = {c, b, t2, d};
      end
      default:
      begin
        s1 = mda_pkg::rotr(e, 5'h06) ^ mda_pkg::rotr(e, 5'h0B) ^
          mda_pkg::rotr(e, 5'h19);
        s0 = mda_pkg::rotr(a, 5'h02) ^ mda_pkg::rotr(a, 5'h0D) ^
          mda_pkg::rotr(a, 5'h16);
        t1 = h + s1 + ((e & f) | (~e & g)) + mda_pkg::K_SHA2[t_in[5:0]] +
          win_in[0];
        t2 = s0 + ((a & b) | (a & c) | (b & c));
        st_out = {g, f, e, d + t1, c, b, a, t1 + t2};
        w_next_out = (mda_pkg::rotr(win_in[14], 5'h11) ^
          mda_pkg::rotr(win_in[14], 5'h13) ^ (win_in[14] >> 10)) +
          win_in[9] + (mda_pkg::rotr(win_in[1], 5'h07) ^
          mda_pkg::rotr(win_in[1], 5'h12) ^ (win_in[1] >> 3)) + win_in[0];
      end
    endcase
  end
endmodule // mda_round

/* mda_top.sv */
// Message digest engine: input path, padding, block sequencing, context
//
// Behaviour
// - SHA-1, SHA2-224, SHA-256, MD5; HMAC by host passes
// - SHA results 160, 224, 256 bits
// - MD5 result is 128 bits
// - 64-bit message length counter
// - 82 cycles SHA-1, 66 SHA-256 per block
// - 66 cycles per MD5 block
// - Per-block result words added to previous ones
// - Words kept in stream order, reordered internally
// - Input swap: none, half, byte, bit
// - Automatic padding to whole 512-bit blocks
// - Sixteen-word input FIFO, one block
// - Non-word access answered with error
// - Eight readable result words, leading ones used
// - One DMA request, single or burst four
// - Context readable and writable at word boundaries
// - Suspend and resume from restored context
`timescale 1ns/1ps
module mda_top
(
  input logic clk_in,
  input logic rst_b_in,
  input logic start_in,
  input logic [1:0] algo_in,
  input logic [1:0] swap_in,
  input logic wr_valid_in,
  input logic [2:0] wr_size_in,
  input logic [31:0] wr_data_in,
  output logic wr_ready_out,
  output logic wr_error_out,
  input logic final_in,
  input logic [4:0] last_bits_in,
  input logic dma_burst_in,
  output logic dma_req_out,
  input logic ctx_wr_in,
  input logic [4:0] ctx_idx_in,
  input logic [31:0] ctx_data_in,
  input logic [4:0] rd_idx_in,
  output logic [31:0] rd_data_out,
  output logic [7:0][31:0] digest_result_words_out,
  input logic irq_en_in,
  output logic irq_out,
  output logic done_out,
  output logic busy_out,
  output logic block_ready_out
);
  typedef struct packed {
    mda_pkg::mda_state_e state;
    mda_pkg::mda_algo_e algo;
    logic [15:0][31:0] fifo;
    logic [4:0] cnt;
    logic [7:0][31:0] dig;
    logic [7:0][31:0] work;
    logic [63:0] len;
    logic [6:0] rnd;
    logic [4:0] bits;
    logic fin_pend;
    logic part;
    logic in_pad;
    logic one;
    logic lp;
    logic last;
    logic done;
    logic err;
    logic [7:0][31:0] res;
    logic [31:0] rd;
  } mda_top_s;

  mda_top_s st;
  mda_top_s next_st;
  logic rst_q1;
  logic rst_sync_b;
  logic buf_valid;
  logic buf_ready;
  logic buf_pop;
  logic [31:0] buf_data;
  logic [1:0] buf_count;
  logic word_ok;
  logic [7:0][31:0] rnd_st;
  logic [31:0] w_next;
  logic [6:0] rounds;
  logic [3:0] nwords;
  logic [3:0] owords;
  logic [5:0] occ;
  logic [3:0] pad_idx;
  logic [31:0] len_w1;
  logic [31:0] len_w2;

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_q1 <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_sync_b <= rst_q1;
    end
  end

  assign word_ok = wr_size_in == mda_pkg::SIZE_WORD;

  mda_buf #(
    .WIDTH(32),
    .DEPTH(2)
  ) u_buf (
    .clk_in(clk_in),
    .rst_b_in(rst_sync_b),
    .in_valid_in(wr_valid_in && word_ok),
    .in_data_in(mda_pkg::swap_word(wr_data_in, swap_in)),
    .in_ready_out(buf_ready),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(buf_pop),
    .count_out(buf_count)
  );

  mda_round u_round (
    .algo_in(st.algo),
    .t_in(7'(st.rnd - 7'h1)),
    .st_in(st.work),
    .win_in(st.fifo),
    .st_out(rnd_st),
    .w_next_out(w_next)
  );

  // Algorithm decode
  always_comb
  begin
    unique case (st.algo)
      mda_pkg::MDA_SHA1:
      begin
        rounds = mda_pkg::ROUNDS_SHA1;
        nwords = 4'h5;
        owords = 4'h5;
      end
      mda_pkg::MDA_SHA224:
      begin
        rounds = mda_pkg::ROUNDS_SHA2;
        nwords = 4'h8;
        owords = 4'h7;
      end
      mda_pkg::MDA_SHA256:
      begin
        rounds = mda_pkg::ROUNDS_SHA2;
        nwords = 4'h8;
        owords = 4'h8;
      end
      mda_pkg::MDA_MD5:
      begin
        rounds = mda_pkg::ROUNDS_MD5;
        nwords = 4'h4;
        owords = 4'h4;
      end
    endcase
  end

  // Length words in stream order for each algorithm
  assign len_w1 = (st.algo == mda_pkg::MDA_MD5) ?
    mda_pkg::bswap(st.len[31:0]) : st.len[63:32];
  assign len_w2 = (st.algo == mda_pkg::MDA_MD5) ?
    mda_pkg::bswap(st.len[63:32]) : st.len[31:0];
  assign pad_idx = 4'(st.cnt - 5'h1);

  always_comb
  begin
    next_st = st;
    buf_pop = 1'b0;
    next_st.err = wr_valid_in && !word_ok;
    // Context read back, registered
    if (rd_idx_in < mda_pkg::RD_DIG)
      next_st.rd = st.fifo[rd_idx_in[3:0]];
    else if (rd_idx_in < mda_pkg::RD_LEN_LO)
      next_st.rd = st.dig[rd_idx_in[2:0]];
    else if (rd_idx_in == mda_pkg::RD_LEN_LO)
      next_st.rd = st.len[31:0];
    else if (rd_idx_in == mda_pkg::RD_LEN_HI)
      next_st.rd = st.len[63:32];
    else if (rd_idx_in == mda_pkg::RD_CNT)
      next_st.rd = {27'h0, st.cnt};
    else
      next_st.rd = '0;

    if (start_in)
    begin
      next_st = '0;
      next_st.rd = st.rd;
      next_st.err = wr_valid_in && !word_ok;
      next_st.state = mda_pkg::MDA_FILL;
      next_st.algo = mda_pkg::mda_algo_e'(algo_in);
      for (int i = 0; i < 8; i++)
      begin
        unique case (mda_pkg::mda_algo_e'(algo_in))
          mda_pkg::MDA_SHA1: next_st.dig[i] = mda_pkg::IV_SHA1[i];
          mda_pkg::MDA_SHA224: next_st.dig[i] = mda_pkg::IV_SHA224[i];
          mda_pkg::MDA_SHA256: next_st.dig[i] = mda_pkg::IV_SHA256[i];
          mda_pkg::MDA_MD5: next_st.dig[i] = mda_pkg::IV_MD5[i];
        endcase
      end
    end
    else
    begin
      unique case (st.state)
        mda_pkg::MDA_IDLE, mda_pkg::MDA_DONE:
        begin
        end
        mda_pkg::MDA_FILL:
        begin
          if (final_in)
          begin
            next_st.fin_pend = 1'b1;
            next_st.bits = last_bits_in;
          end
          // Full FIFO runs once more input waits; finish pads it first
          if (st.cnt == mda_pkg::FIFO_WORDS && buf_valid)
          begin
            next_st.state = mda_pkg::MDA_PROC;
            next_st.rnd = '0;
          end
          else if (st.fin_pend && !buf_valid)
          begin
            next_st.fin_pend = 1'b0;
            next_st.state = mda_pkg::MDA_PAD;
            next_st.in_pad = 1'b1;
            next_st.one = 1'b0;
            next_st.lp = 1'b0;
            next_st.last = 1'b0;
            next_st.part = st.bits != 5'h0;
            if (st.bits != 5'h0)
              next_st.len = st.len - mda_pkg::LEN_STEP + 64'(st.bits);
          end
          else if (buf_valid && st.cnt < mda_pkg::FIFO_WORDS)
          begin
            buf_pop = 1'b1;
            next_st.fifo[st.cnt[3:0]] = buf_data;
            next_st.cnt = st.cnt + 5'h1;
            next_st.len = st.len + mda_pkg::LEN_STEP;
          end
        end
        mda_pkg::MDA_PAD:
        begin
          if (!st.one && st.part)
          begin
            // Mark end of data inside the partial last word
            next_st.fifo[pad_idx] = (st.fifo[pad_idx] &
              ~(32'hFFFFFFFF >> st.bits)) | (mda_pkg::PAD_ONE >> st.bits);
            next_st.one = 1'b1;
          end
          else if (st.cnt == mda_pkg::FIFO_WORDS)
          begin
            next_st.state = mda_pkg::MDA_PROC;
            next_st.rnd = '0;
          end
          else
          begin
            next_st.cnt = st.cnt + 5'h1;
            if (!st.one)
            begin
              next_st.fifo[st.cnt[3:0]] = mda_pkg::PAD_ONE;
              next_st.one = 1'b1;
            end
            else if (st.lp)
            begin
              next_st.fifo[st.cnt[3:0]] = len_w2;
              next_st.last = 1'b1;
            end
            else if (st.cnt == 5'h0E)
            begin
              next_st.fifo[st.cnt[3:0]] = len_w1;
              next_st.lp = 1'b1;
            end
            else
              next_st.fifo[st.cnt[3:0]] = '0;
          end
        end
        mda_pkg::MDA_PROC:
        begin
          next_st.rnd = st.rnd + 7'h1;
          if (st.rnd == 7'h0)
            next_st.work = st.dig;
          else if (st.rnd <= rounds)
          begin
            next_st.work = rnd_st;
            // SHA rounds slide the schedule window; MD5 indexes it
            if (st.algo != mda_pkg::MDA_MD5)
              next_st.fifo = {w_next, st.fifo[15:1]};
          end
          else
          begin
            for (int i = 0; i < 8; i++)
            begin
              if (4'(i) < nwords)
                next_st.dig[i] = st.dig[i] + st.work[i];
              if (st.last)
                next_st.res[i] = (4'(i) < owords) ?
                  st.dig[i] + st.work[i] : '0;
            end
            next_st.cnt = '0;
            next_st.rnd = '0;
            if (st.last)
            begin
              next_st.state = mda_pkg::MDA_DONE;
              next_st.done = 1'b1;
              next_st.in_pad = 1'b0;
            end
            else if (st.in_pad)
              next_st.state = mda_pkg::MDA_PAD;
            else
              next_st.state = mda_pkg::MDA_FILL;
          end
        end
        default:
          next_st.state = mda_pkg::MDA_IDLE;
      endcase
      // Context restore, only outside processing and padding
      if (ctx_wr_in && st.state != mda_pkg::MDA_PROC &&
        st.state != mda_pkg::MDA_PAD)
      begin
        next_st.state = mda_pkg::MDA_FILL;
        next_st.algo = mda_pkg::mda_algo_e'(algo_in);
        next_st.done = 1'b0;
        if (ctx_idx_in < mda_pkg::RD_DIG)
          next_st.fifo[ctx_idx_in[3:0]] = ctx_data_in;
        else if (ctx_idx_in < mda_pkg::RD_LEN_LO)
          next_st.dig[ctx_idx_in[2:0]] = ctx_data_in;
        else if (ctx_idx_in == mda_pkg::RD_LEN_LO)
          next_st.len[31:0] = ctx_data_in;
        else if (ctx_idx_in == mda_pkg::RD_LEN_HI)
          next_st.len[63:32] = ctx_data_in;
        else if (ctx_idx_in == mda_pkg::RD_CNT)
          next_st.cnt = (ctx_data_in[4:0] > mda_pkg::FIFO_WORDS) ?
            mda_pkg::FIFO_WORDS : ctx_data_in[4:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign occ = 6'(st.cnt) + 6'(buf_count);
  // Request only when the whole burst fits
  assign dma_req_out = st.state == mda_pkg::MDA_FILL && !st.fin_pend &&
    (occ + (dma_burst_in ? mda_pkg::DMA_BURST : mda_pkg::DMA_SINGLE)) <=
    6'(mda_pkg::FIFO_WORDS);
  assign wr_ready_out = buf_ready;
  assign wr_error_out = st.err;
  assign rd_data_out = st.rd;
  assign digest_result_words_out = st.res;
  assign done_out = st.done;
  assign irq_out = st.done && irq_en_in;
  assign busy_out = st.state == mda_pkg::MDA_PROC ||
    st.state == mda_pkg::MDA_PAD;
  assign block_ready_out = st.state == mda_pkg::MDA_FILL &&
    st.cnt == 5'h0;
endmodule // mda_top

/* mda_top_assertions.sv */
// Port assertions for the message digest engine
`timescale 1ns/1ps
module mda_checker
(
  input logic clk_in,
  input logic rst_b_in,
  input logic start_in,
  input logic [1:0] algo_in,
  input logic wr_valid_in,
  input logic [2:0] wr_size_in,
  input logic wr_ready_out,
  input logic wr_error_out,
  input logic dma_req_out,
  input logic ctx_wr_in,
  input logic [4:0] rd_idx_in,
  input logic [31:0] rd_data_out,
  input logic [7:0][31:0] digest_result_words_out,
  input logic irq_en_in,
  input logic irq_out,
  input logic done_out,
  input logic busy_out
);
  logic [1:0] algo_q;
  logic [255:0] unused_m;
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      algo_q <= 2'h0;
    else if (start_in || ctx_wr_in)
      algo_q <= algo_in;
  // Digest words beyond the result length
  always_comb
    case (algo_q)
      mda_pkg::MDA_SHA1: unused_m = {{96{1'h1}}, 160'h0};
      mda_pkg::MDA_SHA224: unused_m = {{32{1'h1}}, 224'h0};
      mda_pkg::MDA_MD5: unused_m = {{128{1'h1}}, 128'h0};
      default: unused_m = 256'h0;
    endcase
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_bad_wr;
    wr_valid_in && wr_ready_out && wr_size_in != mda_pkg::SIZE_WORD;
  endsequence
  sequence s_busy_on;
    $rose(busy_out);
  endsequence
  err_pulse_a: assert property (s_bad_wr |=> wr_error_out)
    else $error("bad size write not flagged");
  err_cause_a: assert property (wr_error_out |-> $past(wr_valid_in))
    else $error("error without a write");
  busy_min_a: assert property (s_busy_on |=> busy_out [*8])
    else $error("block too short");
  busy_max_a: assert property (s_busy_on |-> ##[1:400] !busy_out)
    else $error("processing did not end");
  dma_hold_a: assert property (busy_out |-> !dma_req_out)
    else $error("dma request while busy");
  irq_eq_a: assert property (irq_out == (done_out && irq_en_in))
    else $error("irq not done and enable");
  done_src_a: assert property ($rose(done_out) |-> $past(busy_out))
    else $error("done without processing");
  start_clr_a: assert property (start_in |=> !done_out)
    else $error("done kept after start");
  unused_zero_a: assert property (done_out |->
    (digest_result_words_out & unused_m) == 256'h0)
    else $error("unused digest word not zero");
  cnt_max_a: assert property ($past(rd_idx_in) == mda_pkg::RD_CNT |->
    rd_data_out <= 32'h10) else $error("fifo count above one block");
endmodule // mda_checker
bind mda_top mda_checker chk_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .start_in(start_in), .algo_in(algo_in), .wr_valid_in(wr_valid_in),
  .wr_size_in(wr_size_in), .wr_ready_out(wr_ready_out),
  .wr_error_out(wr_error_out), .dma_req_out(dma_req_out),
  .ctx_wr_in(ctx_wr_in), .rd_idx_in(rd_idx_in), .rd_data_out(rd_data_out),
  .digest_result_words_out(digest_result_words_out), .irq_en_in(irq_en_in),
  .irq_out(irq_out), .done_out(done_out), .busy_out(busy_out));

/* mda_top_tb.sv */
// Self-checking bench for the message digest engine
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("Error t=%0t got %h exp %h", $time, g, e); \
    end \
  end
module mda_top_tb;
  logic clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic start, fin, ctx_wr, tb_valid, irq_en, burst, dma_go, dma_valid;
  logic wr_ready, wr_error, dma_req, irq, done, busy, blk_rdy, idle;
  logic [1:0] algo, swap;
  logic [2:0] size;
  logic [4:0] last_bits, ctx_idx, rd_idx;
  logic [31:0] data, dma_data, ctx_d, rd_data;
  logic [7:0][31:0] dig;
  int run, last_run, errors, checks;
  always #5 clk_in = ~clk_in;
  mda_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(start),
    .algo_in(algo), .swap_in(swap), .wr_valid_in(tb_valid | dma_valid),
    .wr_size_in(size), .wr_data_in(dma_valid ? dma_data : data),
    .wr_ready_out(wr_ready), .wr_error_out(wr_error), .final_in(fin),
    .last_bits_in(last_bits), .dma_burst_in(burst), .dma_req_out(dma_req),
    .ctx_wr_in(ctx_wr), .ctx_idx_in(ctx_idx), .ctx_data_in(ctx_d),
    .rd_idx_in(rd_idx), .rd_data_out(rd_data),
    .digest_result_words_out(dig), .irq_en_in(irq_en), .irq_out(irq),
    .done_out(done), .busy_out(busy), .block_ready_out(blk_rdy));
  mda_dma_model dma_u (.clk_in(clk_in), .go_in(dma_go), .words_in(6'h10),
    .burst_in(burst), .req_in(dma_req), .ready_in(wr_ready),
    .valid_out(dma_valid), .data_out(dma_data), .idle_out(idle));
  // Length of the last busy run
  always @(posedge clk_in)
    if (busy === 1'h1)
      run <= run + 1;
    else if (run != 0)
    begin
      last_run <= run;
      run <= 0;
    end
  function automatic logic sel(input int k);
    return k == 0 ? done : (k == 1 ? busy : idle);
  endfunction
  task automatic wt(input int k, input logic v);
    int n = 0;
    while (sel(k) !== v && n++ < 600)
      @(posedge clk_in);
    `CHK(sel(k), v)
  endtask
  task automatic go(input logic [1:0] a);
    @(posedge clk_in);
    algo <= a;
    start <= 1'h1;
    @(posedge clk_in);
    start <= 1'h0;
  endtask
  task automatic wr(input logic [2:0] sz, input logic [31:0] d);
    int n = 0;
    @(posedge clk_in);
    tb_valid <= 1'h1;
    size <= sz;
    data <= d;
    do
      @(posedge clk_in);
    while (wr_ready !== 1'h1 && n++ < 300);
    `CHK(wr_ready, 1'h1)
    tb_valid <= 1'h0;
    size <= mda_pkg::SIZE_WORD;
    data <= ~d;
  endtask
  task automatic rd(input logic [4:0] i, input logic [31:0] e);
    @(posedge clk_in);
    rd_idx <= i;
    repeat (2) @(posedge clk_in);
    `CHK(rd_data, e)
  endtask
  task automatic t_swap();
    logic [31:0] e [4] = '{32'h12345678, 32'h56781234, 32'h78563412,
      32'h1E6A2C48};
    go(mda_pkg::MDA_SHA256);
    for (int m = 0; m < 4; m++)
    begin
      swap <= m[1:0];
      wr(mda_pkg::SIZE_WORD, 32'h12345678);
    end
    wr(3'h1, 32'h0BAD0BAD);
    @(posedge clk_in);
    `CHK(wr_error, 1'h1)
    for (int m = 0; m < 4; m++)
      rd(m[4:0], e[m]);
    rd(mda_pkg::RD_CNT, 32'h4);
    rd(mda_pkg::RD_LEN_LO, 32'h80);
    @(posedge clk_in);
    ctx_wr <= 1'h1;
    @(posedge clk_in);
    ctx_wr <= 1'h0;
    rd(mda_pkg::RD_DIG, 32'hA5A50F0F);
    rd(mda_pkg::RD_CNT, 32'h4);
  endtask
  task automatic t_hash(input logic [1:0] a, input logic [31:0] w0,
    input logic [31:0] w7);
    go(a);
    swap <= mda_pkg::MDA_SW_NONE;
    irq_en <= a[0];
    @(posedge clk_in);
    `CHK(blk_rdy, 1'h1)
    wr(mda_pkg::SIZE_WORD, 32'h61626300);
    fin <= 1'h1;
    @(posedge clk_in);
    fin <= 1'h0;
    wt(0, 1'h1);
    `CHK(dig[0], w0)
    `CHK(dig[7], w7)
    `CHK(irq, a[0])
    rd(mda_pkg::RD_LEN_LO, 32'h18);
  endtask
  task automatic t_blk(input logic [1:0] a, input logic b, input int c);
    go(a);
    burst <= b;
    dma_go <= 1'h1;
    @(posedge clk_in);
    dma_go <= 1'h0;
    @(posedge clk_in);
    wt(2, 1'h1);
    wr(mda_pkg::SIZE_WORD, 32'h5A5A5A5A);
    wt(1, 1'h1);
    wr(mda_pkg::SIZE_WORD, 32'hC3C3C3C3);
    @(posedge clk_in);
    `CHK(wr_ready, 1'h0)
    wt(1, 1'h0);
    @(posedge clk_in);
    `CHK(last_run, c)
  endtask
  task automatic conclude();
    $display("Checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {start, fin, ctx_wr, tb_valid, irq_en, burst, dma_go} = 7'h0;
    {algo, swap, last_bits, rd_idx} = {4'h0, 5'h18, 5'h0};
    {size, ctx_idx, ctx_d, data} = {mda_pkg::SIZE_WORD, mda_pkg::RD_DIG,
      32'hA5A50F0F, 32'h0};
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    t_swap();
    t_hash(mda_pkg::MDA_SHA1, 32'hA9993E36, 32'h0);
    t_hash(mda_pkg::MDA_SHA224, 32'h23097D22, 32'h0);
    t_hash(mda_pkg::MDA_SHA256, 32'hBA7816BF, 32'hF20015AD);
    t_hash(mda_pkg::MDA_MD5, 32'h98500190, 32'h0);
    t_blk(mda_pkg::MDA_SHA1, 1'h1, int'(mda_pkg::BLK_CYC_SHA1));
    t_blk(mda_pkg::MDA_SHA256, 1'h0, int'(mda_pkg::BLK_CYC_SHA2));
    t_blk(mda_pkg::MDA_MD5, 1'h1, int'(mda_pkg::BLK_CYC_MD5));
    conclude();
  end
  initial
  begin
    #200000;
    errors++;
    conclude();
  end
endmodule // mda_top_tb
